//--- logic/sfr_consts.svh
// register offsets, reset values and field positions of the special register bank
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH
`define SFR_ADDR_PORT0 8'h80
`define SFR_ADDR_STACK 8'h81
`define SFR_ADDR_DPLOW 8'h82
`define SFR_ADDR_DPHIGH 8'h83
`define SFR_ADDR_POWER 8'h87
`define SFR_ADDR_TIMCTL 8'h88
`define SFR_ADDR_TIMMODE 8'h89
`define SFR_ADDR_T0LOW 8'h8a
`define SFR_ADDR_T1LOW 8'h8b
`define SFR_ADDR_T0HIGH 8'h8c
`define SFR_ADDR_T1HIGH 8'h8d
`define SFR_ADDR_PORT1 8'h90
`define SFR_ADDR_SERCTL 8'h98
`define SFR_ADDR_SERBUF 8'h99
`define SFR_ADDR_PORT2 8'ha0
`define SFR_ADDR_INTEN 8'ha8
`define SFR_ADDR_PORT3 8'hb0
`define SFR_ADDR_INTPRI 8'hb8
`define SFR_ADDR_T2CTL 8'hc8
`define SFR_ADDR_T2RLOW 8'hca
`define SFR_ADDR_T2RHIGH 8'hcb
`define SFR_ADDR_T2LOW 8'hcc
`define SFR_ADDR_T2HIGH 8'hcd
`define SFR_ADDR_STATUS 8'hd0
`define SFR_ADDR_ACCUM 8'he0
`define SFR_ADDR_OPERB 8'hf0
`define SFR_RST_STACK 8'h07
`define SFR_RST_PORT 8'hff
`define SFR_RST_ZERO 8'h00
`define SFR_PSW_PARITY 0
`define SFR_PSW_BANK_LO 3
`define SFR_PSW_BANK_HI 4
`define SFR_BANK_SPAN 3
`endif

//--- logic/sfr_pkg.sv
// types shared by the special register bank
package sfr_pkg;
   typedef logic [7:0] sfr_byte_t;
   typedef logic [1:0] sfr_bank_t;
endpackage

//--- logic/sfr_regbank.sv
// special function register bank with program status word
//
// Contract
// - accumulator, second operand, status word, stack pointer and power control answer at e0, f0, d0, 81, 87.
// - the data pointer is two separately accessible bytes, low at 82 and high at 83.
// - timer 0/1 count bytes sit at 8a, 8b, 8c, 8d.
// - third timer registers at c8, ca, cb, cc, cd exist only in the extended variant.
// - bit access is honoured only for addresses whose low nibble is 0 or 8.
// - reset loads stack pointer 07, ports ff, other defined bits zero.
// - the two bank-select bits place the working registers at 00, 08, 10 or 18 in RAM.
`timescale 1ns/1ps
`include "sfr_consts.svh"
module sfr_regbank
   import sfr_pkg::*;
#(
   parameter bit EXTENDED = 1'b1
)(
   input wire logic clk_sys, // 40 MHz core clock
   input wire logic sys_rst, // async reset, active high
   input wire logic [7:0] regAddr, // direct address 80..ff
   input wire logic [7:0] wrData, // byte write data
   input wire logic wrStrobe, // byte write, one cycle
   input wire logic rdStrobe, // byte read, one cycle
   input wire logic bitMode, // strobe addresses one bit
   input wire logic [2:0] bitSel, // bit position in bit mode
   input wire logic bitValue, // bit write value
   output logic [7:0] rdData, // read data, cycle after strobe
   output logic rdValid, // read hit a mapped register
   output logic [7:0] accumulator_reg, // accumulator copy
   output logic [7:0] stack_pointer, // stack pointer copy
   output logic [15:0] data_pointer, // data pointer copy
   output logic [4:0] bankBase // working register RAM base
);
   sfr_byte_t regs [0:127];
   sfr_byte_t curByte;
   sfr_byte_t wrByte;
   logic mapped;
   logic bitOk;
   logic doWrite;
   logic accParity;
   sfr_bank_t bankSel;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   always_comb begin
      unique case (regAddr)
         `SFR_ADDR_ACCUM, `SFR_ADDR_OPERB, `SFR_ADDR_STATUS, `SFR_ADDR_STACK, `SFR_ADDR_POWER,
         `SFR_ADDR_DPLOW, `SFR_ADDR_DPHIGH,
         `SFR_ADDR_T0LOW, `SFR_ADDR_T1LOW, `SFR_ADDR_T0HIGH, `SFR_ADDR_T1HIGH,
         `SFR_ADDR_PORT0, `SFR_ADDR_PORT1, `SFR_ADDR_PORT2, `SFR_ADDR_PORT3,
         `SFR_ADDR_TIMCTL, `SFR_ADDR_TIMMODE, `SFR_ADDR_SERCTL, `SFR_ADDR_SERBUF,
         `SFR_ADDR_INTEN, `SFR_ADDR_INTPRI: mapped = 1'b1;
         `SFR_ADDR_T2CTL, `SFR_ADDR_T2RLOW, `SFR_ADDR_T2RHIGH,
         `SFR_ADDR_T2LOW, `SFR_ADDR_T2HIGH: mapped = EXTENDED;
         default: mapped = 1'b0;
      endcase
   end

   assign bitOk = (regAddr[2:0] == 3'h0);
   assign curByte = regs[regAddr[6:0]];
   assign doWrite = wrStrobe && mapped && regAddr[7] && (!bitMode || bitOk);

   always_comb begin
      wrByte = wrData;
      if (bitMode) begin
         wrByte = curByte;
         wrByte[bitSel] = bitValue;
      end
   end

   assign accParity = ^regs[7'(`SFR_ADDR_ACCUM)];

   // ----------------------------------------
   // storage
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 128; i++) begin
            regs[i] <= `SFR_RST_ZERO;
         end
         regs[7'(`SFR_ADDR_STACK)] <= `SFR_RST_STACK;
         regs[7'(`SFR_ADDR_PORT0)] <= `SFR_RST_PORT;
         regs[7'(`SFR_ADDR_PORT1)] <= `SFR_RST_PORT;
         regs[7'(`SFR_ADDR_PORT2)] <= `SFR_RST_PORT;
         regs[7'(`SFR_ADDR_PORT3)] <= `SFR_RST_PORT;
      end else begin
         if (doWrite) begin
            regs[regAddr[6:0]] <= wrByte;
         end
         regs[7'(`SFR_ADDR_STATUS)][`SFR_PSW_PARITY] <= doWrite && regAddr == `SFR_ADDR_ACCUM
            ? ^wrByte : accParity;
      end
   end

   // ----------------------------------------
   // read port and outputs
   // ----------------------------------------
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rdData <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         // unmapped or non-column bit reads return zero
         rdValid <= rdStrobe && mapped && regAddr[7] && (!bitMode || bitOk);
         rdData <= (rdStrobe && mapped && regAddr[7] && (!bitMode || bitOk))
            ? (bitMode ? {7'h00, curByte[bitSel]} : curByte) : 8'h00;
      end
   end

   assign bankSel = regs[7'(`SFR_ADDR_STATUS)][`SFR_PSW_BANK_HI:`SFR_PSW_BANK_LO];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         accumulator_reg <= `SFR_RST_ZERO;
         stack_pointer <= `SFR_RST_STACK;
         data_pointer <= 16'h0000;
         bankBase <= 5'h00;
      end else begin
         accumulator_reg <= doWrite && regAddr == `SFR_ADDR_ACCUM ? wrByte : regs[7'(`SFR_ADDR_ACCUM)];
         stack_pointer <= regs[7'(`SFR_ADDR_STACK)];
         data_pointer <= {regs[7'(`SFR_ADDR_DPHIGH)], regs[7'(`SFR_ADDR_DPLOW)]};
         bankBase <= {bankSel, 3'h0};
      end
   end
endmodule

//--- tb/sfr_core_model.sv
// core-side access model
`timescale 1ns/1ps
module sfr_core_model (
   input wire logic clk_sys, // clock
   input wire logic [7:0] rdData, // read data
   output logic [7:0] regAddr, wrData, // address, data
   output logic wrStrobe, rdStrobe, bitMode, bitValue, // controls
   output logic [2:0] bitSel // bit index
);
   initial {regAddr, wrData, wrStrobe, rdStrobe, bitMode, bitSel, bitValue} = '0;
   // op bit0 write, bit1 bit access; index d[2:0], value d[3]
   task automatic xfer(input logic [1:0] op, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clk_sys);
      {regAddr, wrData, bitMode, bitSel, bitValue} <= {a, d, op[1], d[2:0], d[3]};
      {wrStrobe, rdStrobe} <= {op[0], !op[0]};
      @(posedge clk_sys);
      {wrStrobe, rdStrobe} <= 2'b00;
      @(posedge clk_sys);
      q = rdData;
   endtask
endmodule

//--- tb/sfr_regbank_chk.sv
// port assertions of the register bank
`timescale 1ns/1ps
module sfr_chk (
   input wire logic clk_sys, sys_rst, wrStrobe, rdStrobe, bitMode, rdValid, // controls
   input wire logic [7:0] regAddr, wrData, rdData, accumulator_reg, stack_pointer, // bytes
   input wire logic [4:0] bankBase // bank base
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   wire bw = wrStrobe && !bitMode;
   wire br = rdStrobe && !bitMode;
   AST_ACC: assert property (bw && regAddr == 8'he0 |=> accumulator_reg == $past(wrData)) else $error("acc");
   AST_SP: assert property (bw && regAddr == 8'h81 |=> ##1 stack_pointer == $past(wrData, 2)) else $error("sp");
   AST_MAP: assert property (br && (regAddr == 8'h8a || regAddr == 8'hcd) |=> rdValid)
      else $error("map");
   AST_BANK: assert property (bw && regAddr == 8'hd0 |=> ##1 bankBase == {$past(wrData[4:3], 2), 3'h0})
      else $error("bank");
   AST_PAR: assert property (br && regAddr == 8'hd0 |=> rdData[0] == ^accumulator_reg) else $error("par");
   AST_HOLE: assert property (rdStrobe && regAddr == 8'h84 |=> !rdValid && rdData == 8'h00)
      else $error("hole");
   AST_BIT: assert property (wrStrobe && bitMode && regAddr[2:0] != 3'h0 |=> $stable(stack_pointer))
      else $error("bit");
   AST_RST: assert property ($fell(sys_rst) |-> stack_pointer == 8'h07) else $error("rst");
endmodule
bind sfr_regbank sfr_chk i_chk (.*);

//--- tb/sfr_regbank_tb.sv
// register bank bench
`timescale 1ns/1ps
module sfr_regbank_tb;
   logic clk_sys = 1'b0, sys_rst = 1'b1, wrStrobe, rdStrobe, bitMode, bitValue, rdValid;
   logic [7:0] regAddr, wrData, rdData, accumulator_reg, stack_pointer, q;
   logic [4:0] bankBase;
   logic [15:0] data_pointer;
   logic [2:0] bitSel;
   int error_cnt = 0, checks_done = 0;
   logic [7:0] ad [9] = '{8'h80, 8'hd0, 8'he0, 8'h81, 8'h82, 8'h83, 8'h87, 8'h8a, 8'hcd};
   always #12.5 clk_sys = ~clk_sys;
   sfr_regbank i_dut (.*);
   sfr_core_model i_core (.*);
   task automatic chk(string n, logic [7:0] e, g);
      checks_done++;
      error_cnt += int'(g !== e);
      if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      foreach (ad[i]) begin
         i_core.xfer(2'd0, ad[i], 8'h00, q);
         chk("reset", (i == 0) ? 8'hff : (i == 3) ? 8'h07 : 8'h00, q);
         i_core.xfer(2'd1, ad[i], ad[i] ^ 8'h3c, q);
         i_core.xfer(2'd0, ad[i], 8'h00, q);
         chk("readback", ad[i] ^ 8'h3c, q);
      end
      chk("sp mirror", 8'hbd, stack_pointer);
      chk("dp high", 8'hbf, data_pointer[15:8]);
      chk("dp low", 8'hbe, data_pointer[7:0]);
      // accumulator now holds dc, odd count of ones
      for (int k = 0; k < 4; k++) begin
         i_core.xfer(2'd1, 8'hd0, 8'(k * 8), q);
         i_core.xfer(2'd0, 8'hd0, 8'h00, q);
         chk("status", 8'(k * 8 + 1), q);
         chk("bank", 8'(k * 8), {3'h0, bankBase});
      end
      i_core.xfer(2'd0, 8'h84, 8'h00, q);
      chk("hole", 8'h00, q);
      i_core.xfer(2'd3, 8'he0, 8'h09, q);
      i_core.xfer(2'd3, 8'h81, 8'h00, q);
      chk("acc", 8'hde, accumulator_reg);
      i_core.xfer(2'd2, 8'hd0, 8'h04, q);
      chk("bit", 8'h01, q);
      give_verdict();
   end
endmodule
